// ==== logic/rtcs_pkg.sv ====
package rtcs_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned REF_HZ = 32_768;
  localparam int unsigned RC_NOM_HZ = 32_768;
  localparam int unsigned CMD_W = 8;
  localparam logic [7:0] CMD_TRIM_OSC = 8'hA5;
  localparam int unsigned REF_PERIODS = 65;
  localparam logic [6:0] REF_LAST_IDX = 7'(REF_PERIODS - 1);
  localparam int unsigned TRIM_SHIFT = 6;
  localparam int unsigned PERIOD_W = 16;
  localparam int unsigned MEAS_W = 22;
  localparam logic [PERIOD_W-1:0] RC_DEFAULT_PERIOD = PERIOD_W'(CLK_HZ / RC_NOM_HZ);
  localparam logic [PERIOD_W-1:0] REF_PERIOD = PERIOD_W'(CLK_HZ / REF_HZ);
  localparam logic [PERIOD_W-1:0] RC_MIN_PERIOD = 16'h0004;
  localparam logic [MEAS_W-1:0] MEAS_MAX = {MEAS_W{1'b1}};

  typedef enum logic [1:0] {
    RTCS_DEV_CMD,
    RTCS_DEV_REF,
    RTCS_DEV_FINISHED,
    RTCS_DEV_IGNORE
  } rtcs_dev_state_type;

  typedef enum logic [2:0] {
    RTCS_HOST_IDLE,
    RTCS_HOST_SETUP,
    RTCS_HOST_CMD,
    RTCS_HOST_REF,
    RTCS_HOST_END
  } rtcs_host_state_type;

  // Terminal count of a half-period counter for a full period given in clk cycles
  function automatic logic [PERIOD_W-1:0] rtcs_half_last(input logic [PERIOD_W-1:0] period);
    logic [PERIOD_W-1:0] p;
    p = (period < RC_MIN_PERIOD) ? RC_MIN_PERIOD : period;
    return (p >> 1) - 16'h0001;
  endfunction : rtcs_half_last

endpackage : rtcs_pkg

// ==== logic/rtcs_link_if.sv ====
`timescale 1ns/1ps
interface rtcs_link_if;
  logic sclk;
  logic cs;
  logic host_serial_interface;
  logic crystal_input_pin;

  modport host_end (
    output sclk,
    output cs,
    output host_serial_interface,
    output crystal_input_pin
  );

  modport dev_end (
    input sclk,
    input cs,
    input host_serial_interface,
    input crystal_input_pin
  );
endinterface : rtcs_link_if

// ==== logic/rtcs_sync3.sv ====
`timescale 1ns/1ps
module rtcs_sync3 (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic sync_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;

  // Output only moves once the second and third stage agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        out_q <= s3_q;
      end
    end
  end

  assign sync_out = out_q;

endmodule : rtcs_sync3

// ==== logic/rtcs_host_end.sv ====
`timescale 1ns/1ps
module rtcs_host_end
  import rtcs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic trim_start,
  input wire logic ext_clk_en,
  input wire logic dev_power_down,
  output logic busy,
  output logic trim_done,
  rtcs_link_if.host_end lnk
);

  localparam logic [PERIOD_W-1:0] HALF_LAST = rtcs_half_last(REF_PERIOD);

  rtcs_host_state_type state_q;
  logic [PERIOD_W-1:0] div_q;
  logic [PERIOD_W-1:0] xdiv_q;
  logic [2:0] bit_q;
  logic [6:0] ref_q;
  logic sclk_q;
  logic cs_q;
  logic sdi_q;
  logic xin_q;
  logic busy_q;
  logic done_q;

  wire tick = (div_q == HALF_LAST);
  wire xtick = (xdiv_q == HALF_LAST);
  wire fall = tick & sclk_q;
  wire rise = tick & ~sclk_q;

  // Free reference on the crystal input; parked high in power-down
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xdiv_q <= '0;
      xin_q <= 1'b0;
    end else begin
      xdiv_q <= xtick ? '0 : xdiv_q + 16'h0001;
      if (!ext_clk_en) begin
        xin_q <= 1'b0;
      end else if (dev_power_down) begin
        xin_q <= 1'b1;
      end else if (xtick) begin
        xin_q <= ~xin_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= RTCS_HOST_IDLE;
      div_q <= '0;
      bit_q <= '0;
      ref_q <= '0;
      sclk_q <= 1'b0;
      cs_q <= 1'b0;
      sdi_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      div_q <= (tick || state_q == RTCS_HOST_IDLE) ? '0 : div_q + 16'h0001;
      unique case (state_q)
        RTCS_HOST_IDLE: begin
          if (trim_start) begin
            cs_q <= 1'b1;
            busy_q <= 1'b1;
            state_q <= RTCS_HOST_SETUP;
          end
        end
        RTCS_HOST_SETUP: begin
          if (tick) begin
            sdi_q <= CMD_TRIM_OSC[CMD_W-1];
            bit_q <= '0;
            state_q <= RTCS_HOST_CMD;
          end
        end
        RTCS_HOST_CMD: begin
          if (rise) begin
            sclk_q <= 1'b1;
          end else if (fall) begin
            sclk_q <= 1'b0;
            bit_q <= bit_q + 3'd1;
            if (bit_q == 3'd7) begin
              sdi_q <= 1'b0;
              ref_q <= '0;
              state_q <= RTCS_HOST_REF;
            end else begin
              sdi_q <= CMD_TRIM_OSC[3'd6 - bit_q];
            end
          end
        end
        RTCS_HOST_REF: begin
          if (rise) begin
            sclk_q <= 1'b1;
          end else if (fall) begin
            sclk_q <= 1'b0;
            ref_q <= ref_q + 7'd1;
            if (ref_q == REF_LAST_IDX) begin
              state_q <= RTCS_HOST_END;
            end
          end
        end
        RTCS_HOST_END: begin
          if (tick) begin
            cs_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            state_q <= RTCS_HOST_IDLE;
          end
        end
      endcase
    end
  end

  assign lnk.sclk = sclk_q;
  assign lnk.cs = cs_q;
  assign lnk.host_serial_interface = sdi_q;
  assign lnk.crystal_input_pin = xin_q;
  assign busy = busy_q;
  assign trim_done = done_q;

endmodule : rtcs_host_end

// ==== logic/rtcs_dev_end.sv ====
`timescale 1ns/1ps
// Functional notes
// - Select bit one picks crystal, zero RC
// - Only trim command starts a trim
// - RC off in power-down, reset, crystal on
// - Trim volatile, lost when RC goes off
// - Host holds select high whole sequence
// - Host sends exactly 65 reference periods
// - Host drops select to end trim
// - New trim applied after 65th edge
// - External clock: select one, crystal input
// - External clock held high in power-down
// - Reference at RC nominal frequency, 32768 Hz
module rtcs_dev_end
  import rtcs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_down,
  input wire logic rtc_source_select_bit,
  output logic rtc_clk,
  output logic rco_running,
  output logic trim_valid,
  output logic [PERIOD_W-1:0] trim_period,
  rtcs_link_if.dev_end lnk
);

  // Link side, clocked by the serial clock. Select low clears it, since
  // the serial clock stands still between frames.
  rtcs_dev_state_type lstate_q;
  logic [CMD_W-2:0] shift_q;
  logic [2:0] bit_q;
  logic [6:0] ref_q;
  logic meas_lvl_q;
  logic done_lvl_q;

  wire [CMD_W-1:0] cmd_word = {shift_q, lnk.host_serial_interface};
  wire cmd_is_trim = (cmd_word == CMD_TRIM_OSC);
  wire last_ref = (ref_q == REF_LAST_IDX);

  always_ff @(posedge lnk.sclk or negedge lnk.cs) begin
    if (!lnk.cs) begin
      lstate_q <= RTCS_DEV_CMD;
      shift_q <= '0;
      bit_q <= '0;
      ref_q <= '0;
      meas_lvl_q <= 1'b0;
      done_lvl_q <= 1'b0;
    end else begin
      unique case (lstate_q)
        RTCS_DEV_CMD: begin
          shift_q <= cmd_word[CMD_W-2:0];
          bit_q <= bit_q + 3'd1;
          if (bit_q == 3'd7) begin
            lstate_q <= cmd_is_trim ? RTCS_DEV_REF : RTCS_DEV_IGNORE;
          end
        end
        RTCS_DEV_REF: begin
          ref_q <= ref_q + 7'd1;
          meas_lvl_q <= 1'b1;
          if (last_ref) begin
            done_lvl_q <= 1'b1;
            lstate_q <= RTCS_DEV_FINISHED;
          end
        end
        RTCS_DEV_FINISHED: begin
          lstate_q <= RTCS_DEV_FINISHED;
        end
        RTCS_DEV_IGNORE: begin
          lstate_q <= RTCS_DEV_IGNORE;
        end
      endcase
    end
  end

  // Crossings into the core clock
  logic meas_s;
  logic done_s;
  logic xin_s;

  rtcs_sync3 u_sync_meas (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(meas_lvl_q),
    .sync_out(meas_s)
  );

  rtcs_sync3 u_sync_done (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(done_lvl_q),
    .sync_out(done_s)
  );

  rtcs_sync3 u_sync_xin (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(lnk.crystal_input_pin),
    .sync_out(xin_s)
  );

  // Core side
  logic meas_prev_q;
  logic done_prev_q;
  logic measuring_q;
  logic [MEAS_W-1:0] meas_cnt_q;
  logic trim_valid_q;
  logic [PERIOD_W-1:0] trim_period_q;
  logic rco_running_q;
  logic [PERIOD_W-1:0] rc_cnt_q;
  logic rc_clk_q;
  logic rtc_clk_q;

  wire meas_rise = meas_s & ~meas_prev_q;
  wire done_rise = done_s & ~done_prev_q;
  wire rco_on_d = ~power_down & ~rtc_source_select_bit;
  wire [MEAS_W-1:0] meas_avg = meas_cnt_q >> TRIM_SHIFT;
  // Measured edge-to-edge span covers 64 reference periods
  wire [PERIOD_W-1:0] meas_period = (meas_avg > MEAS_W'({PERIOD_W{1'b1}})) ?
                                    {PERIOD_W{1'b1}} : meas_avg[PERIOD_W-1:0];
  wire [PERIOD_W-1:0] rc_period = trim_valid_q ? trim_period_q : RC_DEFAULT_PERIOD;
  wire [PERIOD_W-1:0] rc_half_last = rtcs_half_last(rc_period);
  wire rc_wrap = (rc_cnt_q >= rc_half_last);
  wire rtc_clk_d = rtc_source_select_bit ? (xin_s & ~power_down) : rc_clk_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meas_prev_q <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      meas_prev_q <= meas_s;
      done_prev_q <= done_s;
    end
  end

  // Cycle count between first and last reference edge
  always_ff @(posedge clk) begin
    if (sys_rst || !rco_on_d) begin
      measuring_q <= 1'b0;
      meas_cnt_q <= '0;
    end else if (meas_rise) begin
      measuring_q <= 1'b1;
      // First cycle of the span counts, else the average reads one low
      meas_cnt_q <= 22'd1;
    end else if (done_rise) begin
      measuring_q <= 1'b0;
    end else if (measuring_q && meas_cnt_q != MEAS_MAX) begin
      meas_cnt_q <= meas_cnt_q + 22'd1;
    end
  end

  // Trim is held in flops only; any RC shutdown drops it
  always_ff @(posedge clk) begin
    if (sys_rst || !rco_on_d) begin
      trim_valid_q <= 1'b0;
      trim_period_q <= RC_DEFAULT_PERIOD;
    end else if (done_rise && measuring_q) begin
      trim_valid_q <= 1'b1;
      trim_period_q <= meas_period;
    end
  end

  // RC oscillator model: half-period divider off the core clock
  always_ff @(posedge clk) begin
    if (sys_rst || !rco_on_d) begin
      rco_running_q <= 1'b0;
      rc_cnt_q <= '0;
      rc_clk_q <= 1'b0;
    end else begin
      rco_running_q <= 1'b1;
      rc_cnt_q <= rc_wrap ? '0 : rc_cnt_q + 16'h0001;
      if (rc_wrap) begin
        rc_clk_q <= ~rc_clk_q;
      end
    end
  end

  // Crystal path and external clock share the synchronised input
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rtc_clk_q <= 1'b0;
    end else begin
      rtc_clk_q <= rtc_clk_d;
    end
  end

  assign rtc_clk = rtc_clk_q;
  assign rco_running = rco_running_q;
  assign trim_valid = trim_valid_q;
  assign trim_period = trim_period_q;

endmodule : rtcs_dev_end

// ==== testbench/rtcs_link_monitor.sv ====
`timescale 1ns/1ps
module rtcs_link_monitor
  import rtcs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic cs,
  input wire logic host_serial_interface,
  input wire logic crystal_input_pin
);
  localparam int FRAME_EDGES = CMD_W + REF_PERIODS;
  logic sclk_q;
  logic [6:0] cnt_q;
  logic [7:0] cmd_q;
  wire edge_up = sclk && !sclk_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Counter cleared by select low, as the device's own link logic is
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
    cnt_q <= !cs ? 7'h00 : cnt_q + 7'(edge_up);
    if (edge_up && cnt_q < 7'(CMD_W)) begin
      cmd_q <= {cmd_q[6:0], host_serial_interface};
    end
  end
  sequence s_low;
    !sclk [*8];
  endsequence
  sequence s_high;
    sclk [*8];
  endsequence
  sequence s_xin_hold;
    $stable(crystal_input_pin) [*8];
  endsequence
  property p_xin_pulse;
    $changed(crystal_input_pin) |=> s_xin_hold;
  endproperty
  property p_idle_still;
    !cs |-> !sclk;
  endproperty
  property p_open;
    $rose(cs) |-> s_low;
  endproperty
  property p_cs_held;
    cs && cnt_q < 7'(FRAME_EDGES) |=> cs;
  endproperty
  property p_sdi_hold;
    cs && edge_up |-> $stable(host_serial_interface);
  endproperty
  property p_cmd;
    cs && cnt_q == 7'(CMD_W) |-> cmd_q == CMD_TRIM_OSC;
  endproperty
  property p_ref_high;
    cs && edge_up && cnt_q >= 7'(CMD_W) |-> s_high;
  endproperty
  property p_ref_low;
    cs && $fell(sclk) |-> s_low;
  endproperty
  property p_count;
    $fell(cs) |-> cnt_q == 7'(FRAME_EDGES);
  endproperty
  property p_no_extra;
    cnt_q <= 7'(FRAME_EDGES);
  endproperty
  property p_close;
    cs && cnt_q == 7'(FRAME_EDGES) && $fell(sclk) |-> cs [*8] ##[1:400] !cs;
  endproperty
  a_idle_still: assert property (p_idle_still) else $error("sclk moves outside frame");
  a_open: assert property (p_open) else $error("no low half after select");
  a_cs_held: assert property (p_cs_held) else $error("select dropped early");
  a_sdi_hold: assert property (p_sdi_hold) else $error("data moved at rise");
  a_cmd: assert property (p_cmd) else $error("wrong command");
  a_ref_high: assert property (p_ref_high) else $error("short high half");
  a_ref_low: assert property (p_ref_low) else $error("short low half");
  a_count: assert property (p_count) else $error("wrong edge count");
  a_no_extra: assert property (p_no_extra) else $error("extra edges");
  a_close: assert property (p_close) else $error("select not dropped");
  a_xin_pulse: assert property (p_xin_pulse) else $error("short pulse on xin");
endmodule : rtcs_link_monitor

// ==== testbench/rtc_source_select_and_trim_bench.sv ====
`timescale 1ns/1ps
module rtc_source_select_and_trim_bench;
  import rtcs_pkg::*;
  localparam int HALF = 305;
  localparam int LINK_HALF = 15;
  localparam int DRV_HALF = 5;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic trim_start = 1'b0;
  logic ext_clk_en = 1'b0;
  logic dev_power_down = 1'b0;
  logic power_down = 1'b0;
  logic src_sel = 1'b0;
  logic busy, trim_done, rtc_clk, rco_running, trim_valid, rco2, valid2;
  logic [PERIOD_W-1:0] trim_period, period2;
  int mismatches = 0;
  int tests_run = 0;
  int n;
  rtcs_link_if lnk();
  rtcs_link_if lnk2();
  always #25 clk = ~clk;
  rtcs_host_end i_rtcs_host_end (.clk(clk), .sys_rst(sys_rst), .trim_start(trim_start),
    .ext_clk_en(ext_clk_en), .dev_power_down(dev_power_down), .busy(busy),
    .trim_done(trim_done), .lnk(lnk));
  rtcs_dev_end i_rtcs_dev_end (.clk(clk), .sys_rst(sys_rst), .power_down(power_down),
    .rtc_source_select_bit(src_sel), .rtc_clk(rtc_clk), .rco_running(rco_running),
    .trim_valid(trim_valid), .trim_period(trim_period), .lnk(lnk));
  // Second device faces the bench driver, which can break the frame
  rtcs_dev_end i_rtcs_dev_end_b (.clk(clk), .sys_rst(sys_rst), .power_down(1'b0),
    .rtc_source_select_bit(1'b0), .rtc_clk(), .rco_running(rco2),
    .trim_valid(valid2), .trim_period(period2), .lnk(lnk2));
  rtcs_link_monitor i_rtcs_link_monitor (.clk(clk), .sys_rst(sys_rst), .sclk(lnk.sclk),
    .cs(lnk.cs), .host_serial_interface(lnk.host_serial_interface), .crystal_input_pin(lnk.crystal_input_pin));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  // Toggles of rtc_clk over a fixed window
  task automatic count_edges(output int cnt);
    logic last;
    last = rtc_clk;
    cnt = 0;
    repeat (1300) begin
      tick(1);
      cnt += int'(rtc_clk !== last);
      last = rtc_clk;
    end
  endtask : count_edges
  // Frame on a 30 ns link clock; nref below 65 aborts mid reference phase
  task automatic drive_frame(input logic [7:0] cmd, input int nref);
    lnk2.cs = 1'b1;
    tick(DRV_HALF);
    for (int i = 0; i < CMD_W + nref; i++) begin
      lnk2.host_serial_interface = (i < CMD_W) ? cmd[CMD_W-1-i] : 1'b0;
      #LINK_HALF;
      lnk2.sclk = 1'b1;
      #LINK_HALF;
      lnk2.sclk = 1'b0;
    end
    tick(DRV_HALF);
    lnk2.cs = 1'b0;
    lnk2.host_serial_interface = 1'b1;
    tick(20);
  endtask : drive_frame
  initial begin
    lnk2.sclk = 1'b0;
    lnk2.cs = 1'b0;
    lnk2.host_serial_interface = 1'b0;
    lnk2.crystal_input_pin = 1'b0;
    tick(5);
    sys_rst = 1'b0;
    tick(2);
    check("period_reset", trim_period, RC_DEFAULT_PERIOD);
    check("rco_on", 16'(rco_running), 16'h0001);
    trim_start = 1'b1;
    tick(1);
    trim_start = 1'b0;
    check("busy_on", 16'(busy), 16'h0001);
    check("cs_on", 16'(lnk.cs), 16'h0001);
    for (n = 0; n < 60000 && trim_done !== 1'b1; n++) tick(1);
    if (n == 60000) begin
      check("trim_done", 16'h0000, 16'h0001);
      report_and_stop();
    end
    check("busy_off", 16'(busy), 16'h0000);
    check("cs_off", 16'(lnk.cs), 16'h0000);
    tick(20);
    check("trim_valid", 16'(trim_valid), 16'h0001);
    check("trim_period", trim_period, 16'((128 * HALF) >> TRIM_SHIFT));
    power_down = 1'b1;
    tick(8);
    check("rco_pd", 16'(rco_running), 16'h0000);
    power_down = 1'b0;
    tick(8);
    check("trim_lost", 16'(trim_valid), 16'h0000);
    count_edges(n);
    check("rc_runs", 16'(n > 2), 16'h0001);
    src_sel = 1'b1;
    tick(8);
    check("rco_xtal", 16'(rco_running), 16'h0000);
    check("rtc_xin_low", 16'(rtc_clk), 16'h0000);
    ext_clk_en = 1'b1;
    dev_power_down = 1'b1;
    tick(2);
    check("xin_parked", 16'(lnk.crystal_input_pin), 16'h0001);
    tick(8);
    check("rtc_xin_high", 16'(rtc_clk), 16'h0001);
    dev_power_down = 1'b0;
    count_edges(n);
    check("ext_runs", 16'(n > 2), 16'h0001);
    drive_frame(8'h5A, 65);
    check("bad_cmd", 16'(valid2), 16'h0000);
    drive_frame(CMD_TRIM_OSC, 30);
    check("abort", 16'(valid2), 16'h0000);
    drive_frame(CMD_TRIM_OSC, 70);
    check("trim_b", 16'(valid2), 16'h0001);
    check("period_b", period2, 16'(((128 * LINK_HALF) / 50) >> TRIM_SHIFT));
    check("rco_b", 16'(rco2), 16'h0001);
    report_and_stop();
  end
endmodule : rtc_source_select_and_trim_bench
